// >>> hdl/e1m_alt_detect.sv
// alternating 1010 pattern detector over 512-bit windows
// assumes one rx_bit_en pulse per received line bit
`timescale 1ns/1ps
`include "e1m_defs.svh"
module e1m_alt_detect (
  input  wire logic sys_clk,
  input  wire logic rstn,
  e1m_rx_if.sink    rx,
  output      logic alt_pattern_flag
);
  import e1m_pkg::*;

  e1m_alt_state_t state;
  logic           prev_bit;
  logic [9:0]     bit_cnt;
  logic [1:0]     err_cnt;
  logic           window_end;

  assign window_end = rx.rx_bit_en && (bit_cnt == `E1M_ALT_WINDOW_BITS - 10'd1);

  // window and error counting; a bit equal to its predecessor breaks alternation
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_bit <= 1'b0;
      bit_cnt  <= 10'h000;
      err_cnt  <= 2'h0;
    end else if (rx.rx_bit_en) begin
      prev_bit <= rx.rx_bit;
      bit_cnt  <= window_end ? 10'h000 : bit_cnt + 10'd1;
      if (window_end) begin
        err_cnt <= 2'h0;
      end else if (rx.rx_bit == prev_bit && err_cnt != 2'h3) begin
        err_cnt <= err_cnt + 2'd1; // saturates, so a noisy window cannot wrap back to clean
      end
    end
  end

  // flag decided once per window; a few errors are tolerated for a 1e-3 line
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= E1M_ALT_SEARCH;
    end else if (window_end) begin
      unique case (state)
        E1M_ALT_SEARCH: if (err_cnt <= `E1M_ALT_ERR_MAX) state <= E1M_ALT_FOUND;
        E1M_ALT_FOUND:  if (err_cnt >  `E1M_ALT_ERR_MAX) state <= E1M_ALT_SEARCH;
        default:        state <= E1M_ALT_SEARCH;
      endcase
    end
  end

  assign alt_pattern_flag = (state == E1M_ALT_FOUND);

  a_alt_window_only: assert property (@(posedge sys_clk) disable iff (!rstn)
    !window_end |=> $stable(state)) else $error("alt flag moved outside window end");
  c_alt_found: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(alt_pattern_flag));
endmodule

// >>> hdl/e1m_los_timer.sv
// line loss-of-signal qualifier: level below threshold for a minimum time
// assumes the analog comparator outputs are already synchronous to sys_clk
`timescale 1ns/1ps
`include "e1m_defs.svh"
module e1m_los_timer #(
  parameter int unsigned LOS_CYCLES = `E1M_LOS_TIME_US * `E1M_CLK_MHZ
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic below_level,
  output      logic line_signal_lost
);
  logic [16:0] low_cnt;

  // count consecutive cycles below threshold; any good cycle restarts the count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt          <= 17'h00000;
      line_signal_lost <= 1'b0;
    end else if (!below_level) begin
      low_cnt          <= 17'h00000;
      line_signal_lost <= 1'b0;
    end else if (low_cnt >= 17'(LOS_CYCLES - 1)) begin
      line_signal_lost <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 17'd1;
    end
  end

  a_los_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    !below_level |=> !line_signal_lost) else $error("loss flag held with good level");
  a_los_needs_time: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(line_signal_lost) |-> low_cnt >= 17'(LOS_CYCLES - 1))
    else $error("loss flag rose too early");
  c_los_seen: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(line_signal_lost));
endmodule

// >>> hdl/e1m_status_top.sv
// e1 receive status monitor: slip, buffer phase, alignment word capture,
// line loss, dejitter fifo status and alternating pattern, read over a plain port
// assumes all inputs synchronous to sys_clk and strobes one cycle long
//
// Contract
// - toggle slip status bit on every controlled receive frame slip
// - slip direction one for repeated frame, zero for lost frame
// - phase word top bit one when buffer delay exceeds one frame
// - flag alternating 1010 stream lasting 512 bits, tolerating errors
// - toggle frame bit on each falling edge of slot count msb
// - report three sub-bit sample depth bits in bits two to zero
// - five-bit slot count between write and read frame boundary, every 250 us
// - three-bit backplane bit count between boundaries, same 250 us refresh
// - alignment word first bit into alignment capture bit seven
// - alignment word bits two to eight into lower seven bits
// - line loss when level stays below threshold at least 1 ms
// - slow and fast flags while dejittered clock stretched or shrunk
// - dejitter fifo empty and full flags
// - dejitter fifo flags for four used, half full, four free
// - non-alignment word first bit into its capture bit seven
// - capture non-alignment marker bit, expected one
// - capture far-end alarm bit from non-alignment word
// - capture national spare bits into five low positions
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "e1m_defs.svh"
module e1m_status_top #(
  parameter int unsigned PHASE_CYCLES = `E1M_PHASE_TIME_US * `E1M_CLK_MHZ,
  parameter int unsigned LOS_CYCLES   = `E1M_LOS_TIME_US * `E1M_CLK_MHZ
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        addr,
  input  wire e1m_pkg::e1m_byte_t wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output      e1m_pkg::e1m_byte_t rd_data,
  input  wire logic              rx_bit,
  input  wire logic              rx_bit_en,
  input  wire logic              rx_ts0_start,
  input  wire logic              frame_aligned,
  input  wire logic              fas_frame,
  input  wire logic              slip_pulse,
  input  wire logic              slip_repeat,
  input  wire logic              ebuf_wr_boundary,
  input  wire logic              bp_bit_en,
  input  wire logic [2:0]        sub_bit_depth,
  input  wire logic              level_below_low,
  input  wire logic              level_below_high,
  input  wire e1m_pkg::e1m_fill_t ja_fill,
  input  wire logic              ja_clk_stretch,
  input  wire logic              ja_clk_shrink
);
  import e1m_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic       slip_event_toggle;
  logic       slip_direction;
  logic       buffer_frame_delay;
  logic       frame_toggle_bit;
  logic [2:0] sub_bit_phase;
  logic [4:0] slot_offset_count;
  logic [2:0] bit_offset_count;
  logic [8:0] bp_cnt;
  logic [13:0] phase_timer;
  logic       phase_tick;
  e1m_byte_t  align_word;
  e1m_byte_t  nonalign_word;
  e1m_byte_t  ts0_shift;
  e1m_byte_t  next_shift;
  logic [3:0] ts0_cnt;
  logic       cap_done;
  logic       los_threshold_select;
  logic       line_signal_lost;
  logic       alt_pattern_flag;
  logic       dejitter_clock_slow;
  logic       dejitter_clock_fast;
  logic       dejitter_fifo_empty;
  logic       dejitter_four_used;
  logic       dejitter_half_full;
  logic       dejitter_four_free;
  logic       dejitter_fifo_full;
  e1m_fill_t  ja_free;

  e1m_rx_if rx_link ();

  assign rx_link.rx_bit    = rx_bit;
  assign rx_link.rx_bit_en = rx_bit_en;

  // ----------------------------------------------------------------------
  // detectors
  // ----------------------------------------------------------------------
  e1m_alt_detect u_alt (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .rx               (rx_link.sink),
    .alt_pattern_flag (alt_pattern_flag)
  );

  // software picks which analog threshold qualifies the loss timer
  e1m_los_timer #(.LOS_CYCLES(LOS_CYCLES)) u_los (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .below_level      (los_threshold_select ? level_below_high : level_below_low),
    .line_signal_lost (line_signal_lost)
  );

  // ----------------------------------------------------------------------
  // controlled slip reporting
  // ----------------------------------------------------------------------
  // either transition of the toggle is one slip, so software compares old and new
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slip_event_toggle <= 1'b0;
      slip_direction    <= 1'b0;
    end else if (slip_pulse) begin
      slip_event_toggle <= ~slip_event_toggle;
      slip_direction    <= slip_repeat;
    end
  end

  // ----------------------------------------------------------------------
  // elastic buffer phase measurement
  // ----------------------------------------------------------------------
  // backplane bits since the buffer write boundary; bit 8 means beyond one frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bp_cnt <= 9'h000;
    end else if (ebuf_wr_boundary) begin
      bp_cnt <= 9'h000;
    end else if (bp_bit_en) begin
      bp_cnt <= bp_cnt + 9'd1;
    end
  end

  assign phase_tick = (phase_timer == 14'(PHASE_CYCLES - 1));

  // free-running refresh timer; sampling only on its tick keeps the word steady for reads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_timer <= 14'h0000;
    end else begin
      phase_timer <= phase_tick ? 14'h0000 : phase_timer + 14'd1;
    end
  end

  // sample the phase word every refresh period
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot_offset_count  <= 5'h00;
      bit_offset_count   <= 3'h0;
      buffer_frame_delay <= 1'b0;
      sub_bit_phase      <= 3'h0;
    end else if (phase_tick) begin
      slot_offset_count  <= bp_cnt[7:3];
      bit_offset_count   <= bp_cnt[2:0];
      buffer_frame_delay <= bp_cnt[8];
      sub_bit_phase      <= sub_bit_depth;
    end
  end

  // frame toggle follows falling edges of the sampled slot count msb
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_toggle_bit <= 1'b0;
    end else if (phase_tick && slot_offset_count[4] && !bp_cnt[7]) begin
      frame_toggle_bit <= ~frame_toggle_bit;
    end
  end

  // ----------------------------------------------------------------------
  // time slot zero capture
  // ----------------------------------------------------------------------
  assign next_shift = {ts0_shift[6:0], rx_bit};
  assign cap_done   = rx_bit_en && (ts0_cnt == 4'd7);

  // bit one arrives first and ends in bit seven after eight shifts
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ts0_shift <= `E1M_RESET_BYTE;
      ts0_cnt   <= 4'h8;
    end else if (rx_bit_en) begin
      if (rx_ts0_start) begin
        ts0_shift <= next_shift;
        ts0_cnt   <= 4'h1;
      end else if (ts0_cnt < 4'h8) begin
        ts0_shift <= next_shift;
        ts0_cnt   <= ts0_cnt + 4'd1;
      end
    end
  end

  // while out of alignment the frame type is unknown, so old captures are kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      align_word    <= `E1M_RESET_BYTE;
      nonalign_word <= `E1M_RESET_BYTE;
    end else if (cap_done && frame_aligned) begin
      if (fas_frame) begin
        align_word <= next_shift;
      end else begin
        nonalign_word <= next_shift;
      end
    end
  end

  // ----------------------------------------------------------------------
  // dejitter fifo status
  // ----------------------------------------------------------------------
  assign ja_free = `E1M_JA_DEPTH - ja_fill;

  // registered so flags sampled from the fill count cannot glitch on a read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dejitter_clock_slow <= 1'b0;
      dejitter_clock_fast <= 1'b0;
      dejitter_fifo_empty <= 1'b1;
      dejitter_four_used  <= 1'b0;
      dejitter_half_full  <= 1'b0;
      dejitter_four_free  <= 1'b0;
      dejitter_fifo_full  <= 1'b0;
    end else begin
      dejitter_clock_slow <= ja_clk_stretch;
      dejitter_clock_fast <= ja_clk_shrink;
      dejitter_fifo_empty <= (ja_fill == 5'd0);
      dejitter_fifo_full  <= (ja_fill >= `E1M_JA_DEPTH);
      dejitter_four_used  <= (ja_fill >= `E1M_JA_FOUR);
      dejitter_half_full  <= (ja_fill >= `E1M_JA_HALF);
      dejitter_four_free  <= (ja_free <= `E1M_JA_FOUR);
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  // read decode used by the port only; unmapped offsets answer zero
  function automatic e1m_byte_t reg_word(input logic [7:0] a);
    e1m_byte_t w;
    w = `E1M_RESET_BYTE;
    unique case (a)
      `E1M_ADDR_SLIP_PHASE_HI: w = {slip_event_toggle, slip_direction, buffer_frame_delay,
                                    alt_pattern_flag, frame_toggle_bit, sub_bit_phase};
      `E1M_ADDR_PHASE_LO:      w = {slot_offset_count, bit_offset_count};
      `E1M_ADDR_ALIGN_CAP:     w = align_word;
      `E1M_ADDR_LINE_STATUS:   w = {line_signal_lost, 7'h00};
      `E1M_ADDR_DEJITTER:      w = {dejitter_clock_slow, dejitter_clock_fast,
                                    dejitter_fifo_empty, dejitter_four_used,
                                    dejitter_half_full, dejitter_four_free,
                                    dejitter_fifo_full, 1'b0};
      `E1M_ADDR_NONALIGN_CAP:  w = nonalign_word;
      `E1M_ADDR_LINE_CTRL:     w = {7'h00, los_threshold_select};
      default:                 w = `E1M_RESET_BYTE;
    endcase
    return w;
  endfunction

  // only the control offset takes writes; status offsets ignore them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      los_threshold_select <= 1'b0;
    end else if (wr_en && addr == `E1M_ADDR_LINE_CTRL) begin
      los_threshold_select <= wr_data[`E1M_BIT_LOS_SELECT];
    end
  end

  // read data stands only in the cycle after the strobe; reads change no state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `E1M_RESET_BYTE;
    end else begin
      rd_data <= rd_en ? reg_word(addr) : `E1M_RESET_BYTE;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_slip_toggles: assert property (slip_pulse |=> slip_event_toggle != $past(slip_event_toggle))
    else $error("slip toggle did not change on slip");
  a_slip_quiet: assert property (!slip_pulse |=> $stable(slip_event_toggle) && $stable(slip_direction))
    else $error("slip bits moved without slip");
  a_slip_dir: assert property (slip_pulse |=> slip_direction == $past(slip_repeat))
    else $error("slip direction wrong");
  a_frame_delay: assert property (phase_tick |=> buffer_frame_delay == $past(bp_cnt[8]))
    else $error("frame delay bit not sampled");
  a_frame_toggle: assert property (phase_tick && slot_offset_count[4] && !bp_cnt[7]
    |=> frame_toggle_bit != $past(frame_toggle_bit)) else $error("frame toggle missed");
  a_phase_hold: assert property (!phase_tick |=> $stable(slot_offset_count)
    && $stable(bit_offset_count) && $stable(sub_bit_phase)) else $error("phase moved early");
  a_phase_period: assert property (phase_tick |=> !phase_tick[*8])
    else $error("phase refresh too frequent");
  a_ja_full_flag: assert property (ja_fill == `E1M_JA_DEPTH |=> dejitter_fifo_full
    && dejitter_half_full && dejitter_four_free && !dejitter_fifo_empty)
    else $error("full fifo flags wrong");
  a_ja_four_used: assert property (ja_fill == 5'd3 |=> !dejitter_four_used && !dejitter_half_full)
    else $error("four used flag early");
  a_ja_clock: assert property (ja_clk_stretch ##1 1'b1 |-> dejitter_clock_slow)
    else $error("slow flag missing");
  a_fas_capture: assert property (cap_done && frame_aligned && fas_frame
    |=> align_word == $past(next_shift) && $stable(nonalign_word))
    else $error("alignment word not captured");
  a_nfas_capture: assert property (cap_done && frame_aligned && !fas_frame
    |=> nonalign_word == $past(next_shift)) else $error("non-alignment word missed");
  a_no_cap_unaligned: assert property (!frame_aligned |=> $stable(align_word)
    && $stable(nonalign_word)) else $error("capture while unaligned");
  // read data checked against the stored word itself, not the decode that makes it
  a_read_align: assert property (rd_en && addr == `E1M_ADDR_ALIGN_CAP
    |=> rd_data == $past(align_word)) else $error("alignment read data wrong");
  a_read_idle: assert property (!rd_en |=> rd_data == `E1M_RESET_BYTE)
    else $error("read data left standing");
  a_status_ro: assert property (wr_en && addr == `E1M_ADDR_ALIGN_CAP && !cap_done
    |=> $stable(align_word)) else $error("status register took a write");

  c_slip: cover property (slip_pulse && slip_repeat);
  c_align_cap: cover property (cap_done && frame_aligned && fas_frame);
  c_nonalign_read: cover property (rd_en && addr == `E1M_ADDR_NONALIGN_CAP);
endmodule

// >>> shared/e1m_defs.svh
// constants of the e1 receive status monitor: offsets, bit fields, timing
// assumes an 8-bit register port and a 50 MHz system clock
`ifndef E1M_DEFS_SVH
`define E1M_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define E1M_ADDR_SLIP_PHASE_HI  8'h12
`define E1M_ADDR_PHASE_LO       8'h13
`define E1M_ADDR_ALIGN_CAP      8'h14
`define E1M_ADDR_LINE_STATUS    8'h15
`define E1M_ADDR_DEJITTER       8'h16
`define E1M_ADDR_NONALIGN_CAP   8'h17
`define E1M_ADDR_LINE_CTRL      8'h1F

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define E1M_BIT_SLIP_TOGGLE     7
`define E1M_BIT_SLIP_DIR        6
`define E1M_BIT_FRAME_DELAY     5
`define E1M_BIT_ALT_PATTERN     4
`define E1M_BIT_FRAME_TOGGLE    3
`define E1M_BIT_LINE_LOST       7
`define E1M_BIT_LOS_SELECT      0
`define E1M_RESET_BYTE          8'h00

// ----------------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------------
`define E1M_CLK_MHZ             50
`define E1M_PHASE_TIME_US       250
`define E1M_LOS_TIME_US         1000
`define E1M_ALT_WINDOW_BITS     10'd512
`define E1M_ALT_ERR_MAX         2'd2
`define E1M_JA_DEPTH            5'd16
`define E1M_JA_FOUR             5'd4
`define E1M_JA_HALF             5'd8

`endif

// >>> shared/e1m_pkg.sv
// types shared by the e1 receive status monitor modules
// assumes nothing beyond a single system clock domain
package e1m_pkg;
  typedef logic [7:0] e1m_byte_t;
  typedef logic [4:0] e1m_fill_t;
  typedef enum logic [1:0] {
    E1M_ALT_SEARCH = 2'b00,
    E1M_ALT_FOUND  = 2'b01
  } e1m_alt_state_t;
endpackage

// >>> shared/e1m_rx_if.sv
// received bit stream carried from the status monitor top to its alternating pattern detector
// assumes rx_bit is valid in cycles where rx_bit_en is high
`timescale 1ns/1ps
interface e1m_rx_if;
  logic rx_bit;
  logic rx_bit_en;
  modport src  (output rx_bit, output rx_bit_en);
  modport sink (input  rx_bit, input  rx_bit_en);
endinterface

// >>> testbench/e1m_line_model.sv
// far-end line model: serialises received bits onto the status monitor's bit port
// assumes the bench calls its tasks; one line bit every two system clocks
`timescale 1ns/1ps
module e1m_line_model (
  input  wire logic sys_clk,
  output      logic rx_bit,
  output      logic rx_bit_en,
  output      logic rx_ts0_start
);
  // ----------------------------------------------------------------
  // bit serialiser
  // ----------------------------------------------------------------
  initial begin
    rx_bit = 1'b0;
    rx_bit_en = 1'b0;
    rx_ts0_start = 1'b0;
  end
  // between bits the line shows the inverse, so a stale bit never reads as good
  task automatic send_bit(input logic b, input logic first);
    @(posedge sys_clk);
    rx_bit       <= b;
    rx_bit_en    <= 1'b1;
    rx_ts0_start <= first;
    @(posedge sys_clk);
    rx_bit       <= ~b;
    rx_bit_en    <= 1'b0;
    rx_ts0_start <= 1'b0;
  endtask
  // time slot zero byte, first bit on the line is bit seven
  task automatic send_ts0(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i], i == 7);
    end
  endtask
endmodule

// >>> testbench/e1m_status_top_bench.sv
// self-checking bench of the e1 receive status monitor
// assumes short phase and loss counts; reads checked through a queue of notes
`timescale 1ns/1ps
module e1m_status_top_bench;
  import e1m_pkg::*;
  logic sys_clk, rstn, wr_en, rd_en, rd_pend, frame_aligned, fas_frame;
  logic slip_pulse, slip_repeat, ebuf_wr_boundary, bp_bit_en, lo, hi, st, sh;
  logic rx_bit, rx_bit_en, rx_ts0_start, tog, dir;
  logic [7:0] addr;
  logic [2:0] sub;
  e1m_byte_t  wr_data, rd_data, cap14, cap17, v;
  e1m_fill_t  ja_fill;
  e1m_byte_t  notes[$];
  int         bad_count, n_tests;
  int         seed = 32'h51f9e281;
  e1m_status_top #(.PHASE_CYCLES(20), .LOS_CYCLES(10)) i_e1m_status_top (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
    .rx_ts0_start(rx_ts0_start), .frame_aligned(frame_aligned), .fas_frame(fas_frame),
    .slip_pulse(slip_pulse), .slip_repeat(slip_repeat),
    .ebuf_wr_boundary(ebuf_wr_boundary), .bp_bit_en(bp_bit_en), .sub_bit_depth(sub),
    .level_below_low(lo), .level_below_high(hi), .ja_fill(ja_fill),
    .ja_clk_stretch(st), .ja_clk_shrink(sh));
  e1m_line_model i_e1m_line_model (.sys_clk(sys_clk), .rx_bit(rx_bit),
    .rx_bit_en(rx_bit_en), .rx_ts0_start(rx_ts0_start));
  // ----------------------------------------------------------------
  // clock, checking and closing
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic check(input e1m_byte_t seen, input e1m_byte_t exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  // read data stand only in the cycle after the strobe, so compare exactly there
  always @(posedge sys_clk) begin
    if (rd_pend === 1'b1) begin
      check(rd_data, notes.pop_front());
    end
    rd_pend <= rd_en;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(20 * 40000);
    bad_count++;
    conclude();
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input e1m_byte_t exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    notes.push_back(exp);
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input e1m_byte_t d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, wr_en, rd_en, frame_aligned, fas_frame, slip_pulse} = '0;
    {slip_repeat, ebuf_wr_boundary, bp_bit_en, lo, hi, st, sh, tog, dir} = '0;
    {addr, wr_data, sub, ja_fill, cap14, cap17} = '0;
    wait_clk(5);
    rstn <= 1'b1;
    for (int a = 8'h12; a <= 8'h17; a++) begin
      rd(a[7:0], (a == 8'h16) ? 8'h20 : 8'h00);
    end
    $display("test reset done");
    // phase: 300 backplane bits past the write boundary, slot msb falls once
    sub <= 3'($random(seed));
    ebuf_wr_boundary <= 1'b1;
    wait_clk(1);
    ebuf_wr_boundary <= 1'b0;
    repeat (300) begin
      bp_bit_en <= 1'b1;
      wait_clk(1);
      bp_bit_en <= 1'b0;
      wait_clk(1);
    end
    wait_clk(25);
    rd(8'h13, 8'h2C);
    rd(8'h12, {tog, dir, 1'b1, 1'b0, 1'b1, sub});
    $display("test phase done");
    repeat (4) begin
      slip_repeat <= 1'($random(seed));
      slip_pulse <= 1'b1;
      wait_clk(1);
      slip_pulse <= 1'b0;
      dir = slip_repeat;
      tog = ~tog;
      wait_clk(2);
      rd(8'h12, {tog, dir, 1'b1, 1'b0, 1'b1, sub});
    end
    $display("test slip done");
    // captures land only while aligned, routed by frame type
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      frame_aligned <= ~i[1];
      fas_frame <= ~i[0];
      i_e1m_line_model.send_ts0(v);
      if (!i[1] && !i[0]) cap14 = v;
      if (!i[1] && i[0]) cap17 = v;
      wait_clk(2);
      wr(8'h14, ~v);
      rd(8'h14, cap14);
      rd(8'h17, cap17);
    end
    $display("test capture done");
    for (int m = 0; m < 2; m++) begin
      for (int b = 0; b < 1100; b++) begin
        i_e1m_line_model.send_bit(m == 0 ? b[0] : 1'b1, 1'b0);
      end
      wait_clk(25);
      rd(8'h12, {tog, dir, 1'b1, m == 0, 1'b1, sub});
    end
    $display("test pattern done");
    // loss qualifier under each threshold select, with a short dip first
    lo <= 1'b1;
    wait_clk(6);
    lo <= 1'b0;
    rd(8'h15, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(8'h1F, 8'(s));
      {hi, lo} <= s ? 2'b01 : 2'b10;
      wait_clk(15);
      rd(8'h15, 8'h00);
      {hi, lo} <= s ? 2'b10 : 2'b01;
      wait_clk(15);
      rd(8'h15, 8'h80);
      {hi, lo} <= 2'b00;
      wr(8'h15, 8'hFF);
      wait_clk(2);
      rd(8'h15, 8'h00);
    end
    rd(8'h1F, 8'h01);
    rd(8'h20, 8'h00);
    $display("test loss done");
    for (int f = 0; f <= 16; f++) begin
      ja_fill <= 5'(f);
      {st, sh} <= 2'($random(seed));
      wait_clk(3);
      rd(8'h16, {st, sh, f == 0, f >= 4, f >= 8, f >= 12, f == 16, 1'b0});
    end
    wait_clk(3);
    $display("test dejitter done");
    conclude();
  end
endmodule
